// ### verilog/wit_pkg.sv
// Constants shared by the watchdog/interval timer: register map, keys,
// field positions, reset values and cycle counts.
// Assumes a 200 MHz core clock; all counts are in core clock cycles.
package wit_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_TCS_WR = 32'hFFFF_8610; // Shared count/control write word.
  localparam logic [31:0] ADDR_RCS_WR = 32'hFFFF_8612; // Reset control write word.
  localparam logic [31:0] ADDR_TCS_RD = 32'hFFFF_8610; // Control/status byte read.
  localparam logic [31:0] ADDR_CNT_RD = 32'hFFFF_8611; // Counter byte read.
  localparam logic [31:0] ADDR_RCS_RD = 32'hFFFF_8613; // Reset control byte read.

  // ----------------------------------------------------------------
  // Write keys carried in the upper byte of a word write
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_COUNT      = 8'h5A;
  localparam logic [7:0] KEY_CTRL       = 8'hA5;
  localparam logic [7:0] RCS_CLEAR_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TCS_FLAG_BIT = 7;
  localparam int TCS_MODE_BIT = 6;
  localparam int TCS_RUN_BIT  = 5;
  localparam int TCS_SEL_MSB  = 2;
  localparam int RCS_FLAG_BIT = 7;
  localparam int RCS_EN_BIT   = 6;
  localparam int RCS_TYPE_BIT = 5;

  // ----------------------------------------------------------------
  // Reset values and read masks
  // ----------------------------------------------------------------
  localparam logic [7:0] TCS_RESET     = 8'h18;
  localparam logic [7:0] RCS_RESET     = 8'h1F;
  localparam logic [7:0] CNT_RESET     = 8'h00;
  localparam logic [7:0] TCS_RSVD_MASK = 8'h18; // Reserved bits read as one.
  localparam logic [7:0] RCS_RSVD_MASK = 8'h1F;
  localparam logic [7:0] COUNT_MAX     = 8'hFF;
  localparam logic [2:0] SEL_RESET     = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int OUT_LOW_CYCLES = 128;
  localparam int INT_RST_CYCLES = 512;
  localparam int PRESCALE_W     = 13;
  // Log2 of the eight division ratios 2..8192, in select-code order.
  localparam int DIV_SHIFT [8] = '{1, 6, 7, 8, 9, 10, 12, 13};

  // Bus access size.
  typedef enum logic [1:0] {
    WIT_SZ_BYTE = 2'b00,
    WIT_SZ_WORD = 2'b01,
    WIT_SZ_LONG = 2'b10
  } wit_size_e;

endpackage

// ### verilog/wit_tick_if.sv
// Interface carrying the eight divided-clock enable pulses.
// Assumes producer and consumer share core_clk.
`timescale 1ns/1ps
interface wit_tick_if;
  logic [7:0] tick;
  modport source (output tick);
  modport sink   (input  tick);
endinterface

// ### verilog/wit_prescaler.sv
// Free-running prescaler producing one-cycle enables at eight rates.
// Assumes a synchronous active-high reset on core_clk.
`timescale 1ns/1ps
module wit_prescaler (
  // Clock and reset
  input  logic          core_clk,
  input  logic          rst,
  // Enable pulses
  wit_tick_if.source    ticks
);
  import wit_pkg::*;

  logic [PRESCALE_W-1:0] prescale_reg;

  // The counter never stops, so every rate stays phase-locked to the others.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= prescale_reg + 1'b1;
    end
  end

  // RULE23: rate enables
  // Each enable fires when the low bits of the prescaler are all ones.
  for (genvar i = 0; i < 8; i++) begin : g_tick
    assign ticks.tick[i] = &prescale_reg[DIV_SHIFT[i]-1:0];
  end

  chk_tick_fast_rate: assert property ( // RULE23
    @(posedge core_clk) disable iff (rst) ticks.tick[0] |=> !ticks.tick[0] ##1 ticks.tick[0])
    else $error("Divide-by-2 enable is not every second cycle.");

endmodule

// ### verilog/wit_pulse.sv
// Fixed-length pulse generator with a selectable idle level.
// Assumes fire is a one-cycle strobe; a new fire restarts the pulse.
`timescale 1ns/1ps
module wit_pulse #(
  parameter int         LENGTH = 128,
  parameter logic       IDLE   = 1'b0
) (
  // Clock and reset
  input  logic core_clk,
  input  logic rst,
  // Trigger and output
  input  logic fire,
  output logic level_reg
);
  localparam int CW = $clog2(LENGTH + 1);

  if (LENGTH < 1) begin : g_bad_len
    $error("Pulse length must be at least one cycle.");
  end

  logic [CW-1:0] left_reg;

  // The output turns active the cycle after fire and stays so for LENGTH cycles.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      left_reg  <= '0;
      level_reg <= IDLE;
    end else if (fire) begin
      left_reg  <= CW'(LENGTH);
      level_reg <= ~IDLE;
    end else if (left_reg != '0) begin
      left_reg  <= left_reg - 1'b1;
      if (left_reg == CW'(1)) begin
        level_reg <= IDLE;
      end
    end
  end

endmodule

// ### verilog/wit_timer.sv
// Watchdog / interval timer top: keyed register port, 8-bit counter,
// overflow output, interval interrupt and internal reset request.
// Assumes bus strobes are synchronous to core_clk and last one cycle.
//
// Notes on behaviour
// RULE1: Eight-bit up-counter advances on selected enable while run is set.
// RULE2: Wrap from FF to 00 raises overflow output or interval interrupt.
// RULE3: Counter clears on power-on and while run is zero; standby keeps it.
// RULE4: External manual reset leaves counter alone; watchdog self-reset clears it.
// RULE5: Flag, mode and run clear on power-on and on standby entry.
// RULE6: Clock select clears on power-on, survives standby.
// RULE7: Control fields survive external manual reset, clear on watchdog self-reset.
// RULE8: Control bits four and three always read as one.
// RULE9: Interval flag sets on interval-mode overflow only, never in watchdog mode.
// RULE10: Flag clears only after being read as one, then written zero.
// RULE11: Writing one to either status bit seven does nothing.
// RULE12: Mode zero gives interval interrupt, mode one the external overflow output.
// RULE13: Run zero holds counter at zero; run one starts counting.
// RULE14: Select codes pick divide by 2,64,128,256,512,1024,4096,8192.
// RULE15: Overflow comes 256 selected periods after counting starts at zero.
// RULE16: Watchdog overflow drives output and optionally a typed internal reset.
// RULE17: Software writes these registers only with word accesses.
// RULE18: Software reads these registers only with byte accesses.
// RULE19: Shared word address: key 5A loads counter, A5 loads control, others ignored.
// RULE20: Reset control: A5 with 00 clears flag; 5A copies bits six and five.
// RULE21: Overflow output stays low for 128 clock cycles.
// RULE22: Internal reset request lasts 512 cycles, starting with the overflow output.
// RULE23: Counter rates are one-cycle enables from a free-running prescaler.
`timescale 1ns/1ps
module wit_timer (
  // Clock and power-on reset
  input  logic              core_clk,
  input  logic              rst,
  // Standby mode level from the power controller
  input  logic              standby,
  // Register port
  input  logic              bus_rd_en,
  input  logic              bus_wr_en,
  input  wit_pkg::wit_size_e bus_size,
  input  logic [31:0]       bus_addr,
  input  logic [15:0]       bus_wdata,
  output logic [7:0]        bus_rdata,
  // Timer outputs
  output logic              overflow_out_n,
  output logic              interval_irq,
  output logic              internal_reset_req,
  output logic              internal_reset_manual
);
  import wit_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] watchdog_count_reg;
  logic       interval_overflow_flag_reg;
  logic       mode_select_reg;
  logic       timer_run_reg;
  logic [2:0] clock_div_select_reg;
  logic       watchdog_overflow_flag_reg;
  logic       internal_reset_enable_reg;
  logic       internal_reset_type_reg;
  logic       flag_seen_reg;
  logic       wd_flag_seen_reg;
  logic [7:0] rdata_reg;
  logic       reset_manual_reg;
  logic       out_level_n;
  logic       rst_level;

  wit_tick_if ticks ();

  wit_prescaler u_prescaler (
    .core_clk (core_clk),
    .rst      (rst),
    .ticks    (ticks)
  );

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // RULE17: word writes only
  // RULE19: key decode
  // Byte and long writes never match, so they leave every register untouched.
  wire       wr_word    = bus_wr_en && (bus_size == WIT_SZ_WORD);
  wire [7:0] wr_key     = bus_wdata[15:8];
  wire [7:0] wr_low     = bus_wdata[7:0];
  wire       wr_cnt     = wr_word && (bus_addr == ADDR_TCS_WR) && (wr_key == KEY_COUNT);
  wire       wr_tcs     = wr_word && (bus_addr == ADDR_TCS_WR) && (wr_key == KEY_CTRL);
  // RULE20: reset control keys
  wire       wr_rcs_clr = wr_word && (bus_addr == ADDR_RCS_WR) && (wr_key == KEY_CTRL)
                          && (wr_low == RCS_CLEAR_DATA);
  wire       wr_rcs_cfg = wr_word && (bus_addr == ADDR_RCS_WR) && (wr_key == KEY_COUNT);
  // RULE18: byte reads only
  wire       rd_byte    = bus_rd_en && (bus_size == WIT_SZ_BYTE);
  wire       rd_tcs     = rd_byte && (bus_addr == ADDR_TCS_RD);
  wire       rd_cnt     = rd_byte && (bus_addr == ADDR_CNT_RD);
  wire       rd_rcs     = rd_byte && (bus_addr == ADDR_RCS_RD);

  // ----------------------------------------------------------------
  // Counting and overflow
  // ----------------------------------------------------------------
  // RULE14: rate select
  wire tick_sel  = ticks.tick[clock_div_select_reg];
  // RULE13: run gating
  // Standby gates the count enable, so the counter holds its value while standby is high.
  wire count_en  = timer_run_reg && tick_sel && !standby;
  // RULE2: wrap detection
  // A keyed counter write in the same cycle wins, so no overflow is reported.
  wire overflow  = count_en && (watchdog_count_reg == COUNT_MAX) && !wr_cnt;
  // RULE12: mode routing
  wire wdt_wrap  = overflow && mode_select_reg;
  wire itv_wrap  = overflow && !mode_select_reg;
  // RULE16: optional internal reset
  wire rst_fire  = wdt_wrap && internal_reset_enable_reg;

  // RULE3: clear and hold
  // RULE4: self-reset clears
  // RULE15: 256 enable periods
  // The counter has no manual-reset input: an external manual reset leaves it alone.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      watchdog_count_reg <= CNT_RESET;
    end else if (standby) begin
      watchdog_count_reg <= watchdog_count_reg;
    end else if (wdt_wrap || !timer_run_reg) begin
      watchdog_count_reg <= CNT_RESET;
    end else if (wr_cnt) begin
      watchdog_count_reg <= wr_low;
    end else if (count_en) begin
      // RULE1: count up
      watchdog_count_reg <= watchdog_count_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Timer control/status
  // ----------------------------------------------------------------
  // RULE10: read-then-write clear
  // RULE11: write one ignored
  // The clear needs a prior read of the flag as one; any keyed control write uses that read up.
  wire flag_clr    = wr_tcs && !wr_low[TCS_FLAG_BIT] && flag_seen_reg;
  wire wd_flag_clr = wr_rcs_clr && wd_flag_seen_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_seen_reg    <= 1'b0;
      wd_flag_seen_reg <= 1'b0;
    end else begin
      flag_seen_reg    <= rd_tcs ? interval_overflow_flag_reg : (flag_seen_reg && !wr_tcs);
      wd_flag_seen_reg <= rd_rcs ? watchdog_overflow_flag_reg : (wd_flag_seen_reg && !wr_rcs_clr);
    end
  end

  // RULE5: standby clears
  // RULE9: interval-only flag
  // The set beats a same-cycle clear so an overflow is never lost.
  always_ff @(posedge core_clk) begin
    if (rst || standby || wdt_wrap) begin
      interval_overflow_flag_reg <= TCS_RESET[TCS_FLAG_BIT];
    end else if (itv_wrap) begin
      interval_overflow_flag_reg <= 1'b1;
    end else if (flag_clr) begin
      interval_overflow_flag_reg <= 1'b0;
    end
  end

  // RULE7: self-reset initializes
  // A watchdog overflow always reinitializes the control fields, which stops the count.
  always_ff @(posedge core_clk) begin
    if (rst || wdt_wrap) begin
      mode_select_reg <= TCS_RESET[TCS_MODE_BIT];
      timer_run_reg   <= TCS_RESET[TCS_RUN_BIT];
    end else if (standby) begin
      mode_select_reg <= 1'b0;
      timer_run_reg   <= 1'b0;
    end else if (wr_tcs) begin
      mode_select_reg <= wr_low[TCS_MODE_BIT];
      timer_run_reg   <= wr_low[TCS_RUN_BIT];
    end
  end

  // RULE6: select survives standby
  always_ff @(posedge core_clk) begin
    if (rst || wdt_wrap) begin
      clock_div_select_reg <= SEL_RESET;
    end else if (wr_tcs && !standby) begin
      clock_div_select_reg <= wr_low[TCS_SEL_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Reset control/status
  // ----------------------------------------------------------------
  // RULE20: flag and config writes
  // Standby returns the register to its reset image; the watchdog's own reset does not.
  always_ff @(posedge core_clk) begin
    if (rst || standby) begin
      watchdog_overflow_flag_reg <= RCS_RESET[RCS_FLAG_BIT];
      internal_reset_enable_reg  <= RCS_RESET[RCS_EN_BIT];
      internal_reset_type_reg    <= RCS_RESET[RCS_TYPE_BIT];
    end else begin
      if (wdt_wrap) begin
        watchdog_overflow_flag_reg <= 1'b1;
      end else if (wd_flag_clr) begin
        watchdog_overflow_flag_reg <= 1'b0;
      end
      if (wr_rcs_cfg) begin
        internal_reset_enable_reg <= wr_low[RCS_EN_BIT];
        internal_reset_type_reg   <= wr_low[RCS_TYPE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // RULE8: reserved ones
  wire [7:0] tcs_view = {interval_overflow_flag_reg, mode_select_reg, timer_run_reg, 2'b00,
                         clock_div_select_reg} | TCS_RSVD_MASK;
  wire [7:0] rcs_view = {watchdog_overflow_flag_reg, internal_reset_enable_reg,
                         internal_reset_type_reg, 5'h00} | RCS_RSVD_MASK;
  wire [7:0] rd_mux   = rd_tcs ? tcs_view :
                        rd_cnt ? watchdog_count_reg :
                        rd_rcs ? rcs_view : 8'h00;

  // Read data is registered and answers one cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (bus_rd_en) begin
      rdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Output pulses
  // ----------------------------------------------------------------
  // RULE21: overflow output
  wit_pulse #(.LENGTH(OUT_LOW_CYCLES), .IDLE(1'b1)) u_out_pulse (
    .core_clk  (core_clk),
    .rst       (rst),
    .fire      (wdt_wrap),
    .level_reg (out_level_n)
  );

  // RULE22: internal reset
  wit_pulse #(.LENGTH(INT_RST_CYCLES), .IDLE(1'b0)) u_rst_pulse (
    .core_clk  (core_clk),
    .rst       (rst),
    .fire      (rst_fire),
    .level_reg (rst_level)
  );

  // The type is latched at the overflow so a later write cannot change a pulse in flight.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_manual_reg <= 1'b0;
    end else if (rst_fire) begin
      reset_manual_reg <= internal_reset_type_reg;
    end
  end

  assign bus_rdata             = rdata_reg;
  assign overflow_out_n        = out_level_n;
  assign interval_irq          = interval_overflow_flag_reg;
  assign internal_reset_req    = rst_level;
  assign internal_reset_manual = reset_manual_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [9:0] rst_len_reg;
  always_ff @(posedge core_clk) begin
    if (rst || !internal_reset_req) begin
      rst_len_reg <= 10'h000;
    end else begin
      rst_len_reg <= rst_len_reg + 10'h001;
    end
  end

  sequence s_out_low;
    !overflow_out_n ##127 !overflow_out_n ##1 overflow_out_n;
  endsequence

  sequence s_cleared_ctrl;
    !timer_run_reg && !mode_select_reg && (clock_div_select_reg == SEL_RESET);
  endsequence

  chk_count_step: assert property ( // RULE1
    (count_en && !wr_cnt && (watchdog_count_reg != COUNT_MAX))
      |=> watchdog_count_reg == $past(watchdog_count_reg) + 8'h01)
    else $error("Counter did not advance on its enable.");

  chk_wrap_flag: assert property ( // RULE2
    itv_wrap |=> (watchdog_count_reg == CNT_RESET) && interval_overflow_flag_reg && interval_irq)
    else $error("Interval wrap did not clear counter and raise the interrupt.");

  chk_idle_hold: assert property ( // RULE13
    (!timer_run_reg && !standby) |=> watchdog_count_reg == CNT_RESET)
    else $error("Counter not held at zero while stopped.");

  chk_standby_clear: assert property ( // RULE5
    standby |=> !timer_run_reg && !mode_select_reg && !interval_overflow_flag_reg
                && (watchdog_count_reg == $past(watchdog_count_reg)))
    else $error("Standby did not clear control bits or disturbed the counter.");

  chk_wd_no_flag: assert property ( // RULE9
    (mode_select_reg && !interval_overflow_flag_reg) |=> !interval_overflow_flag_reg)
    else $error("Interval flag set in watchdog mode.");

  chk_flag_needs_read: assert property ( // RULE10
    (interval_overflow_flag_reg && wr_tcs && !flag_seen_reg && !standby && !wdt_wrap)
      |=> interval_overflow_flag_reg)
    else $error("Flag cleared without a prior read.");

  chk_wd_flag_one: assert property ( // RULE11
    (!watchdog_overflow_flag_reg && !wdt_wrap) |=> !watchdog_overflow_flag_reg)
    else $error("Watchdog flag set without an overflow.");

  chk_ctrl_write: assert property ( // RULE19
    (wr_tcs && !standby && !wdt_wrap)
      |=> (mode_select_reg == $past(bus_wdata[TCS_MODE_BIT]))
          && (clock_div_select_reg == $past(bus_wdata[TCS_SEL_MSB:0])))
    else $error("Keyed control write was not taken.");

  chk_self_clear: assert property ( // RULE7
    wdt_wrap |=> s_cleared_ctrl ##0 watchdog_overflow_flag_reg)
    else $error("Watchdog overflow did not reinitialize control.");

  chk_out_low_len: assert property ( // RULE21
    wdt_wrap |-> ##1 s_out_low)
    else $error("Overflow output not low for exactly 128 cycles.");

  chk_reset_len: assert property ( // RULE22
    $fell(internal_reset_req) |-> rst_len_reg == 10'(INT_RST_CYCLES))
    else $error("Internal reset request not 512 cycles long.");

  chk_reset_with_ovf: assert property ( // RULE16
    rst_fire |=> internal_reset_req && !overflow_out_n
                 && (internal_reset_manual == $past(internal_reset_type_reg)))
    else $error("Internal reset did not start with the overflow output.");

endmodule

// ### tb/wit_cpu_model.sv
// Bus master model standing in for the processor core.
// Assumes the timer samples its strobes on the rising core_clk edge.
`timescale 1ns/1ps
module wit_cpu_model (
  // Clock
  input  wire logic          core_clk,
  // Register port
  output logic               bus_rd_en,
  output logic               bus_wr_en,
  output wit_pkg::wit_size_e bus_size,
  output logic [31:0]        bus_addr,
  output logic [15:0]        bus_wdata
);
  import wit_pkg::*;

  // Idle bus at time zero.
  initial begin
    bus_rd_en = 1'b0;
    bus_wr_en = 1'b0;
    bus_size  = WIT_SZ_BYTE;
    bus_addr  = 32'h0000_0000;
    bus_wdata = 16'h0000;
  end

  // One access: strobe held for one edge, released lines scrambled so
  // the design cannot lean on stale values.
  task automatic access(input logic wr, input logic [31:0] a,
                        input logic [15:0] d, input wit_size_e s);
    @(posedge core_clk);
    #1;
    bus_addr  = a;
    bus_wdata = d;
    bus_size  = s;
    bus_wr_en = wr;
    bus_rd_en = !wr;
    @(posedge core_clk);
    #1;
    bus_wr_en = 1'b0;
    bus_rd_en = 1'b0;
    bus_addr  = ~a;
    bus_wdata = ~d;
  endtask
endmodule

// ### tb/wit_timer_tb_top.sv
// Self-checking bench for the watchdog / interval timer.
// Assumes the bus master model drives the register port.
`timescale 1ns/1ps
module wit_timer_tb_top;
  import wit_pkg::*;
  logic        core_clk, rst, standby, bus_rd_en, bus_wr_en;
  wit_size_e   bus_size;
  logic [31:0] bus_addr;
  logic [15:0] bus_wdata;
  logic [7:0]  bus_rdata, r, exp_q[$];
  logic        overflow_out_n, interval_irq, internal_reset_req, internal_reset_manual;
  logic        rd_seen = 1'b0;
  int          errors = 0, n_tests = 0, n, m, d;

  wit_cpu_model cpu_u (.core_clk(core_clk), .bus_rd_en(bus_rd_en), .bus_wr_en(bus_wr_en),
                       .bus_size(bus_size), .bus_addr(bus_addr), .bus_wdata(bus_wdata));
  wit_timer dut_u (.core_clk(core_clk), .rst(rst), .standby(standby), .bus_rd_en(bus_rd_en),
                   .bus_wr_en(bus_wr_en), .bus_size(bus_size), .bus_addr(bus_addr),
                   .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .overflow_out_n(overflow_out_n),
                   .interval_irq(interval_irq), .internal_reset_req(internal_reset_req),
                   .internal_reset_manual(internal_reset_manual));

  // 200 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Read data is settled one cycle after the strobe; take the oldest note.
  always @(posedge core_clk) begin
    if (rd_seen) begin
      check(bus_rdata, exp_q.pop_front());
    end
    rd_seen <= bus_rd_en;
  end

  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    cpu_u.access(1'b1, a, v, WIT_SZ_WORD);
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cpu_u.access(1'b0, a, 16'h0000, WIT_SZ_BYTE);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return interval_irq;
      1: return overflow_out_n;
      default: return internal_reset_req;
    endcase
  endfunction

  // Bounded wait; a hang counts as a mismatch and ends the run.
  task automatic wait_for(input int w, input logic v, input int lim, output int c);
    c = 0;
    while (pick(w) !== v) begin
      @(posedge core_clk);
      #1;
      c++;
      if (c > lim) begin
        errors++;
        stop_test();
      end
    end
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1;
    standby = 1'b0;
    void'($urandom(32'hc0a6));
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    rd(ADDR_TCS_RD, TCS_RESET);
    rd(ADDR_CNT_RD, CNT_RESET);
    rd(ADDR_RCS_RD, RCS_RESET);
    rd(32'hFFFF_8614, 8'h00);
    exp_q.push_back(8'h00);
    cpu_u.access(1'b0, ADDR_TCS_RD, 16'h0000, WIT_SZ_WORD);
    // Byte, long and wrongly keyed writes must all be dropped.
    cpu_u.access(1'b1, ADDR_TCS_WR, 16'hA527, WIT_SZ_BYTE);
    cpu_u.access(1'b1, ADDR_TCS_WR, 16'hA527, WIT_SZ_LONG);
    wr(ADDR_TCS_WR, 16'h3C27);
    rd(ADDR_TCS_RD, 8'h18);
    wr(ADDR_TCS_WR, 16'h5A77);
    rd(ADDR_CNT_RD, 8'h00);
    r = 8'($urandom());
    wr(ADDR_TCS_WR, 16'hA53F);
    wr(ADDR_TCS_WR, {KEY_COUNT, r});
    rd(ADDR_CNT_RD, r);
    rd(ADDR_TCS_RD, 8'h3F);
    // Full interval from zero at the fastest rate.
    wr(ADDR_TCS_WR, 16'hA518);
    wr(ADDR_TCS_WR, 16'hA538);
    wait_for(0, 1'b1, 600, n);
    check(n >= 510 && n <= 514, 1'b1);
    rd(ADDR_TCS_RD, 8'hB8);
    wr(ADDR_TCS_WR, 16'hA538);
    // Every select code: wrap time, flag read, refused and proper clear.
    for (int c = 0; c < 8; c++) begin
      d = 1 << DIV_SHIFT[c];
      wr(ADDR_TCS_WR, 16'hA518);
      wr(ADDR_TCS_WR, {KEY_CTRL, 8'hB8 | 8'(c)});
      wr(ADDR_TCS_WR, {KEY_COUNT, 8'hFE});
      wait_for(0, 1'b1, 3 * d, n);
      check(n > d && n <= 2 * d + 2, 1'b1);
      wr(ADDR_TCS_WR, {KEY_CTRL, 8'h38 | 8'(c)});
      check(interval_irq, 1'b1);
      rd(ADDR_TCS_RD, 8'hB8 | 8'(c));
      wr(ADDR_TCS_WR, {KEY_CTRL, 8'h38 | 8'(c)});
      check(interval_irq, 1'b0);
    end
    // Watchdog overflow with a manual-type internal reset.
    wr(ADDR_RCS_WR, 16'h5A60);
    rd(ADDR_RCS_RD, 8'h7F);
    wr(ADDR_TCS_WR, 16'hA578);
    wr(ADDR_TCS_WR, 16'h5AFE);
    wait_for(1, 1'b0, 20, n);
    check(internal_reset_req, 1'b1);
    check(internal_reset_manual, 1'b1);
    wait_for(1, 1'b1, 200, n);
    check(n, 16'd128);
    wait_for(2, 1'b0, 600, m);
    check(n + m, 16'd512);
    check(interval_irq, 1'b0);
    rd(ADDR_TCS_RD, TCS_RESET);
    rd(ADDR_CNT_RD, 8'h00);
    rd(ADDR_RCS_RD, 8'hFF);
    wr(ADDR_RCS_WR, 16'hA501);
    rd(ADDR_RCS_RD, 8'hFF);
    wr(ADDR_RCS_WR, {KEY_CTRL, RCS_CLEAR_DATA});
    rd(ADDR_RCS_RD, 8'h7F);
    // Standby clears run fields, keeps the select code.
    wr(ADDR_TCS_WR, 16'hA53D);
    standby = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    standby = 1'b0;
    rd(ADDR_TCS_RD, 8'h1D);
    rd(ADDR_CNT_RD, 8'h00);
    rd(ADDR_RCS_RD, RCS_RESET);
    // Power-on type reset, an unread flag clear refused, then an overflow with reset disabled.
    wr(ADDR_RCS_WR, 16'h5A40);
    wr(ADDR_TCS_WR, 16'hA578);
    wr(ADDR_TCS_WR, 16'h5AFE);
    wait_for(1, 1'b0, 20, n);
    check(internal_reset_req, 1'b1);
    check(internal_reset_manual, 1'b0);
    wr(ADDR_RCS_WR, {KEY_CTRL, RCS_CLEAR_DATA});
    rd(ADDR_RCS_RD, 8'hDF);
    wr(ADDR_RCS_WR, {KEY_CTRL, RCS_CLEAR_DATA});
    rd(ADDR_RCS_RD, 8'h5F);
    wait_for(2, 1'b0, 600, m);
    wr(ADDR_RCS_WR, 16'h5A00);
    wr(ADDR_TCS_WR, 16'hA578);
    wr(ADDR_TCS_WR, 16'h5AFE);
    wait_for(1, 1'b0, 20, n);
    check(internal_reset_req, 1'b0);
    repeat (4) @(posedge core_clk);
    stop_test();
  end
endmodule
